// ### core/rclv_pkg.sv
// Package for the reset cause and low supply flag block.
// Assumes a single 250 MHz clock domain and an active-low async reset.
package rclv_pkg;
    // Clock period in ns
    localparam int unsigned CLK_PERIOD_NS   = 4;
    // Least pulse width accepted on the reset pin, in ns
    localparam int unsigned PIN_FILTER_NS   = 100;
    // Filter count; the pin must stay low one cycle more than this before a reset is accepted (rounded up)
    localparam int unsigned PIN_FILTER_CYC  =
        (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Width of the glitch filter counter
    localparam int unsigned FILT_W          = 8;
    // Reset pulse counter load; the internal reset pulse lasts one cycle less
    localparam int unsigned RST_HOLD_CYC    = 4;
    // Flag values after power-on: power-on 0, time-out 1, power-down 1
    localparam logic        POR_FLAG_RST    = 1'b0;
    localparam logic        TO_FLAG_RST     = 1'b1;
    localparam logic        PD_FLAG_RST     = 1'b1;
    localparam logic        LOW_FLAG_RST    = 1'b0;
    // Bit position of the low supply flag in the power control register
    localparam int unsigned LOW_FLAG_BIT    = 0;
    localparam int unsigned POWER_CONTROL_REG_W          = 2;

    // Reset cause recorded for software
    typedef enum logic [2:0] {
        RCLV_CAUSE_POR,
        RCLV_CAUSE_PIN_RUN,
        RCLV_CAUSE_PIN_SLEEP,
        RCLV_CAUSE_WDOG_RUN,
        RCLV_CAUSE_WDOG_WAKE,
        RCLV_CAUSE_INT_WAKE
    } rclv_cause_type;
endpackage

// ### core/rclv_pin_if.sv
// Interface between the top block and the pin glitch filter.
// Assumes both ends run on the same clock.
interface rclv_pin_if;
    logic pin_low;  // Synchronised pin level, high while pin is low
    logic accepted; // Filtered low level, high once a real reset is seen
    modport filt (input pin_low, output accepted);
    modport top  (output pin_low, input accepted);
endinterface

// ### core/rclv_glitch_filter.sv
// Glitch filter for the external reset pin.
// Assumes the input is already synchronised to clk_i.
module rclv_glitch_filter
    import rclv_pkg::*;
#(
    parameter int unsigned FILT_CYC = PIN_FILTER_CYC
) (
    input  wire logic  clk_i,
    input  wire logic  resetn_i,
    rclv_pin_if.filt   pin
);
    import rclv_pkg::*;

    // All state of the filter
    typedef struct packed {
        logic [FILT_W-1:0] cnt;
        logic              acc;
    } rclv_filt_type;

    rclv_filt_type s_q, s_d;

    // Count consecutive low cycles; any high level restarts the count
    always_comb begin
        s_d = s_q;
        if (!pin.pin_low) begin
            s_d.cnt = '0;
            s_d.acc = 1'b0;
        end else if (s_q.cnt < FILT_W'(FILT_CYC)) begin
            s_d.cnt = s_q.cnt + FILT_W'(1); // see R9
        end else begin
            s_d.acc = 1'b1;                 // see R9
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin.accepted = s_q.acc;
endmodule

// ### core/rclv_top.sv
// Reset cause discrimination and low supply flag.
// Assumes resetn_i is the power-on reset, the pin and the supply comparator
// are asynchronous, and watchdog, sleep and wake inputs are on clk_i.
// Function
// R1: Classify power-on, pin run/sleep, watchdog resets.
// R2: Reset-immune registers keep value except power-on.
// R3: Ordinary registers reset, except watchdog wake.
// R4: Power-on gives flags 0,1,1.
// R5: Watchdog reset running gives 1,0,1.
// R6: Watchdog wake from sleep gives 1,0,0.
// R7: Pin reset running gives 1,1,1.
// R8: Pin reset or interrupt wake sleeping: 1,1,0.
// R9: Glitch filter rejects short reset pin pulses.
// R10: Watchdog reset never drives reset pin low.
// R11: Low supply clears power control bit 0.
// R12: Software alone sets low supply flag again.
// R13: Flag stays cleared after supply recovers.
module rclv_top
    import rclv_pkg::*;
#(
    parameter int unsigned FILT_CYC = PIN_FILTER_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  external_reset_pin_n_i,
    input  wire logic                  supply_low_i,
    input  wire logic                  watchdog_timeout_i,
    input  wire logic                  sleeping_i,
    input  wire logic                  int_wake_i,
    input  wire logic                  flag_wr_i,
    input  wire logic                  flag_wr_data_i,
    input  wire logic                  por_flag_wr_i,
    output logic                       por_flag_n_o,
    output logic                       timeout_flag_n_o,
    output logic                       powerdown_flag_n_o,
    output logic                       low_supply_flag_n_o,
    output logic [POWER_CONTROL_REG_W-1:0]          power_control_reg_o,
    output rclv_pkg::rclv_cause_type   cause_o,
    output logic                       ordinary_reset_o,
    output logic                       resume_o,
    output logic                       external_reset_pin_n_o,
    output logic                       external_reset_pin_n_oe_o
);
    import rclv_pkg::*;

    // All state of the block
    typedef struct packed {
        logic           pin_s1;    // Synchroniser stage one for the pin
        logic           pin_s2;    // Synchroniser stage two
        logic           sup_s1;    // Synchroniser stage one for the comparator
        logic           sup_s2;    // Synchroniser stage two
        logic           pin_held;  // Pin reset already counted, wait for release
        logic           por_f;     // Power-on flag, active low
        logic           to_f;      // Time-out flag, active low
        logic           pd_f;      // Power-down flag, active low
        logic           low_f;     // Low supply flag, active low
        rclv_cause_type cause;     // Last reset cause
        logic [2:0]     hold;      // Ordinary reset pulse counter
        logic           ord_rst;   // Ordinary register reset pulse
        logic           resume;    // Wake-up resume pulse
    } rclv_state_type;

    rclv_state_type s_q, s_d;
    rclv_pin_if     pin_bus ();

    // Filter sees only the second synchroniser stage
    assign pin_bus.pin_low = ~s_q.pin_s2;

    rclv_glitch_filter #(
        .FILT_CYC (FILT_CYC)
    ) u_filt (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .pin      (pin_bus.filt)
    );

    // Load the three cause flags in one place
    function automatic rclv_state_type set_flags(input rclv_state_type s,
                                                 input logic to_v,
                                                 input logic pd_v);
        rclv_state_type r;
        r      = s;
        r.por_f = 1'b1;
        r.to_f  = to_v;
        r.pd_f  = pd_v;
        return r;
    endfunction

    // Event decode, flag update and reset pulse generation
    always_comb begin
        s_d        = s_q;
        s_d.pin_s1 = external_reset_pin_n_i;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.sup_s1 = supply_low_i;
        s_d.sup_s2 = s_q.sup_s1;
        s_d.resume = 1'b0;
        if (s_q.hold != 3'h0) begin
            s_d.hold = s_q.hold - 3'h1;
        end
        s_d.ord_rst = (s_q.hold > 3'h1);
        if (!pin_bus.accepted) begin
            s_d.pin_held = 1'b0;
        end
        // Software writes the power-on flag high once it has seen a power-on
        if (por_flag_wr_i) begin
            s_d.por_f = 1'b1;
        end
        if (pin_bus.accepted && !s_q.pin_held) begin
            // Filtered pin reset; sleep state picks the cause
            s_d.pin_held = 1'b1;
            s_d.hold     = 3'(RST_HOLD_CYC);                 // see R3
            if (sleeping_i) begin
                s_d       = set_flags(s_d, 1'b1, 1'b0);      // see R8
                s_d.cause = RCLV_CAUSE_PIN_SLEEP;            // see R1
            end else begin
                s_d       = set_flags(s_d, 1'b1, 1'b1);      // see R7
                s_d.cause = RCLV_CAUSE_PIN_RUN;              // see R1
            end
        end else if (watchdog_timeout_i) begin
            if (sleeping_i) begin
                // Wake-up: ordinary registers keep state, execution resumes
                s_d        = set_flags(s_d, 1'b0, 1'b0);     // see R6
                s_d.cause  = RCLV_CAUSE_WDOG_WAKE;           // see R1
                s_d.resume = 1'b1;                           // see R3
            end else begin
                // Internal only; the pin driver is never enabled
                s_d       = set_flags(s_d, 1'b0, 1'b1);      // see R5, R10
                s_d.cause = RCLV_CAUSE_WDOG_RUN;             // see R1
                s_d.hold  = 3'(RST_HOLD_CYC);                // see R3
            end
        end else if (int_wake_i && sleeping_i) begin
            s_d        = set_flags(s_d, 1'b1, 1'b0);         // see R8
            s_d.cause  = RCLV_CAUSE_INT_WAKE;
            s_d.resume = 1'b1;
        end
        // Software sets the low flag; a low supply wins over the write
        if (flag_wr_i && flag_wr_data_i) begin
            s_d.low_f = 1'b1;                                // see R12
        end else if (flag_wr_i) begin
            s_d.low_f = 1'b0;
        end
        // Recovery above the upper trip point never sets it back
        if (s_q.sup_s2) begin
            s_d.low_f = 1'b0;                                // see R11, R13
        end
    end

    // State register; power-on is the asynchronous reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q          <= '0;
            s_q.por_f    <= POR_FLAG_RST;                    // see R4
            s_q.to_f     <= TO_FLAG_RST;                     // see R4
            s_q.pd_f     <= PD_FLAG_RST;                     // see R4
            s_q.low_f    <= LOW_FLAG_RST;                    // see R2
            s_q.cause    <= RCLV_CAUSE_POR;                  // see R1
            s_q.pin_s1   <= 1'b1;
            s_q.pin_s2   <= 1'b1;
            s_q.hold     <= 3'(RST_HOLD_CYC);                // see R3
            s_q.ord_rst  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign por_flag_n_o           = s_q.por_f;
    assign timeout_flag_n_o       = s_q.to_f;
    assign powerdown_flag_n_o     = s_q.pd_f;
    assign low_supply_flag_n_o    = s_q.low_f;
    assign power_control_reg_o    = {s_q.por_f, s_q.low_f};
    assign cause_o                = s_q.cause;
    assign ordinary_reset_o       = s_q.ord_rst;
    assign resume_o               = s_q.resume;
    // Pin is an input only; reset stays internal
    assign external_reset_pin_n_o    = 1'b1;                 // see R10
    assign external_reset_pin_n_oe_o = 1'b0;                 // see R10
endmodule

// ### tb/rclv_checker.sv
// Concurrent checks on the reset cause and low supply flag block.
// Assumes it is bound to rclv_top and sees nothing but its ports.
module rclv_checker
    import rclv_pkg::*;
(
    input wire logic                     clk_i,
    input wire logic                     resetn_i,
    input wire logic                     external_reset_pin_n_i,
    input wire logic                     supply_low_i,
    input wire logic                     watchdog_timeout_i,
    input wire logic                     sleeping_i,
    input wire logic                     int_wake_i,
    input wire logic                     flag_wr_i,
    input wire logic                     flag_wr_data_i,
    input wire logic                     por_flag_wr_i,
    input wire logic                     por_flag_n_o,
    input wire logic                     timeout_flag_n_o,
    input wire logic                     powerdown_flag_n_o,
    input wire logic                     low_supply_flag_n_o,
    input wire logic [POWER_CONTROL_REG_W-1:0]        power_control_reg_o,
    input wire rclv_pkg::rclv_cause_type cause_o,
    input wire logic                     ordinary_reset_o,
    input wire logic                     resume_o,
    input wire logic                     external_reset_pin_n_o,
    input wire logic                     external_reset_pin_n_oe_o
);
    // One clock domain, so clocking and reset qualification are shared
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Watchdog run, watchdog wake flag and interrupt wake checks demand a quiet pin, since a pin reset wins the same cycle
    a_por_flags: assert property ($rose(resetn_i) |-> {por_flag_n_o, timeout_flag_n_o, powerdown_flag_n_o} == 3'h3 && cause_o == RCLV_CAUSE_POR)
        else $error("flags after power-on wrong");
    a_wdog_run_flags: assert property (watchdog_timeout_i && !sleeping_i && external_reset_pin_n_i && $past(external_reset_pin_n_i, 8) |=> {por_flag_n_o, timeout_flag_n_o, powerdown_flag_n_o} == 3'h5 && cause_o == RCLV_CAUSE_WDOG_RUN)
        else $error("watchdog reset flags wrong");
    a_wdog_run_reset: assert property (watchdog_timeout_i && !sleeping_i && external_reset_pin_n_i && $past(external_reset_pin_n_i, 8) |=> ##1 ordinary_reset_o [*3])
        else $error("watchdog reset did not reset registers");
    a_wdog_wake_flags: assert property (watchdog_timeout_i && sleeping_i && external_reset_pin_n_i && $past(external_reset_pin_n_i, 8) |=> {por_flag_n_o, timeout_flag_n_o, powerdown_flag_n_o} == 3'h4 && resume_o && cause_o == RCLV_CAUSE_WDOG_WAKE)
        else $error("watchdog wake flags wrong");
    a_wake_keeps_regs: assert property (watchdog_timeout_i && sleeping_i |=> !ordinary_reset_o [*4])
        else $error("watchdog wake reset registers");
    a_int_wake_flags: assert property (int_wake_i && sleeping_i && !watchdog_timeout_i && external_reset_pin_n_i && $past(external_reset_pin_n_i, 8) |=> {por_flag_n_o, timeout_flag_n_o, powerdown_flag_n_o} == 3'h6 && resume_o && cause_o == RCLV_CAUSE_INT_WAKE)
        else $error("interrupt wake flags wrong");
    a_pin_not_pulled: assert property (watchdog_timeout_i |-> !external_reset_pin_n_oe_o [*6])
        else $error("reset pin driven after watchdog");
    a_low_clear: assert property (supply_low_i [*3] |=> !low_supply_flag_n_o)
        else $error("low supply did not clear flag");
    a_low_sticky: assert property (!low_supply_flag_n_o && !(flag_wr_i && flag_wr_data_i) |=> !low_supply_flag_n_o)
        else $error("low supply flag set without write");
    a_low_write_sets: assert property (flag_wr_i && flag_wr_data_i && !supply_low_i && !$past(supply_low_i) && !$past(supply_low_i, 2) |=> low_supply_flag_n_o)
        else $error("flag write did not set low supply flag");
    a_power_control_reg_low_bit: assert property (power_control_reg_o[LOW_FLAG_BIT] == low_supply_flag_n_o)
        else $error("power control bit 0 differs from flag");
endmodule

bind rclv_top rclv_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .external_reset_pin_n_i(external_reset_pin_n_i),
    .supply_low_i(supply_low_i), .watchdog_timeout_i(watchdog_timeout_i), .sleeping_i(sleeping_i),
    .int_wake_i(int_wake_i), .flag_wr_i(flag_wr_i), .flag_wr_data_i(flag_wr_data_i), .por_flag_wr_i(por_flag_wr_i),
    .por_flag_n_o(por_flag_n_o), .timeout_flag_n_o(timeout_flag_n_o), .powerdown_flag_n_o(powerdown_flag_n_o),
    .low_supply_flag_n_o(low_supply_flag_n_o), .power_control_reg_o(power_control_reg_o), .cause_o(cause_o),
    .ordinary_reset_o(ordinary_reset_o), .resume_o(resume_o), .external_reset_pin_n_o(external_reset_pin_n_o),
    .external_reset_pin_n_oe_o(external_reset_pin_n_oe_o));

// ### tb/rclv_tb.sv
// Self-checking bench for the reset cause and low supply flag block.
// Assumes the package, interface and design modules are compiled first.
module tb
    import rclv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, resetn_i = 1'b0, external_reset_pin_n_i = 1'b1, supply_low_i = 1'b0;
    logic watchdog_timeout_i = 1'b0, sleeping_i = 1'b0, int_wake_i = 1'b0;
    logic flag_wr_i = 1'b0, flag_wr_data_i = 1'b0, por_flag_wr_i = 1'b0;
    logic por_n, to_n, pd_n, low_n, ord_rst, resume, pin_o, pin_oe;
    logic [POWER_CONTROL_REG_W-1:0] power_control_reg;  // Power control register view
    rclv_cause_type    cause; // Recorded reset cause
    int error_cnt = 0, check_count = 0, seed, op, exp_low;
    // Scenario table: sleep, watchdog, wake, pin low cycles, flags, cause
    int sl_t[6] = '{0, 0, 0, 1, 1, 1};
    int wd_t[6] = '{1, 0, 0, 0, 1, 0};
    int iw_t[6] = '{0, 0, 0, 0, 0, 1};
    int pl_t[6] = '{0, 1, 20, 20, 0, 0};
    int ef_t[6] = '{5, 5, 7, 6, 4, 6};
    rclv_cause_type ec_t[6] = '{RCLV_CAUSE_WDOG_RUN, RCLV_CAUSE_WDOG_RUN, RCLV_CAUSE_PIN_RUN,
        RCLV_CAUSE_PIN_SLEEP, RCLV_CAUSE_WDOG_WAKE, RCLV_CAUSE_INT_WAKE};
    // Short filter count keeps pin scenarios brief
    rclv_top #(.FILT_CYC(3)) DUT (.clk_i(clk_i), .resetn_i(resetn_i),
        .external_reset_pin_n_i(external_reset_pin_n_i), .supply_low_i(supply_low_i),
        .watchdog_timeout_i(watchdog_timeout_i), .sleeping_i(sleeping_i), .int_wake_i(int_wake_i),
        .flag_wr_i(flag_wr_i), .flag_wr_data_i(flag_wr_data_i), .por_flag_wr_i(por_flag_wr_i),
        .por_flag_n_o(por_n), .timeout_flag_n_o(to_n), .powerdown_flag_n_o(pd_n),
        .low_supply_flag_n_o(low_n), .power_control_reg_o(power_control_reg), .cause_o(cause),
        .ordinary_reset_o(ord_rst), .resume_o(resume), .external_reset_pin_n_o(pin_o),
        .external_reset_pin_n_oe_o(pin_oe));
    // 250 MHz clock
    always #2 clk_i = ~clk_i;
    // Compare one result with the model
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Print the counts and the verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Inputs move only on the falling edge
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Hang guard, generous against about 300 expected cycles
    initial begin
        #16000;
        error_cnt++;
        summarize();
    end
    // Main sequence
    initial begin
        seed = $urandom(32'h5459);
        tick(2);
        resetn_i = 1'b1;
        tick(5);
        chk(8'({por_n, to_n, pd_n}), 8'h03);
        chk(8'(cause), 8'(RCLV_CAUSE_POR));
        chk(8'(power_control_reg), 8'h00);
        por_flag_wr_i = 1'b1;
        tick(1);
        por_flag_wr_i = 1'b0;
        tick(2);
        chk(8'(por_n), 8'h01);
        // Glitch length is random but always below the filter count
        pl_t[1] = 1 + int'($urandom % 2);
        for (int k = 0; k < 6; k++) begin
            sleeping_i = sl_t[k][0];
            watchdog_timeout_i = wd_t[k][0];
            int_wake_i = iw_t[k][0];
            external_reset_pin_n_i = (pl_t[k] == 0);
            tick(1);
            watchdog_timeout_i = 1'b0;
            int_wake_i = 1'b0;
            tick(pl_t[k]);
            external_reset_pin_n_i = 1'b1;
            tick(12);
            sleeping_i = 1'b0;
            chk(8'({por_n, to_n, pd_n}), 8'(ef_t[k]));
            chk(8'(cause), 8'(ec_t[k]));
            chk(8'({pin_o, pin_oe, ord_rst}), 8'h04);
            tick(4);
            $display("event test %0d done", k);
        end
        // Random mix of flag writes and low supply episodes
        exp_low = 0;
        for (int i = 0; i < 24; i++) begin
            op = int'($urandom % 3);
            if (op == 2) begin
                supply_low_i = 1'b1;
                tick(3 + int'($urandom % 4));
                supply_low_i = 1'b0;
                exp_low = 0;
            end else begin
                flag_wr_i = 1'b1;
                flag_wr_data_i = (op == 0);
                tick(1);
                flag_wr_i = 1'b0;
                exp_low = (op == 0);
            end
            tick(4);
            chk(8'(low_n), 8'(exp_low));
            chk(8'(power_control_reg[0]), 8'(exp_low));
        end
        $display("low supply test done");
        summarize();
    end
endmodule
